// ### rtl/vsi_regs.sv
/*
 * vsi_regs: APB register bank selecting the colour standard, its modifiers,
 * the luma and chroma inputs and the front-end filters, with a modelled
 * standard initialization and a completion interrupt.
 * Assumes an APB3 master on pclk; zero wait states.
 */
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - the 3-bit standard code picks one of eight colour standards.
// - the modifier bit gives simple PAL, compensated NTSC or monochrome.
// - one bit switches separate luma/chroma mode off or on.
// - two option bits skip hpll setup or acc setup during initialization.
// - standard status is written zero and set when switching completes.
// - any input selection write starts a full standard initialization.
// - IF compensation offers off, 6 dB, 12 dB, or 10 dB/MHz for SECAM.
// - notch bit picks adaptive or fixed SECAM notch.
// - lowpass bit enables the luma lowpass filter.
// - input status is written zero and set when the operation completes.
// - picture start position applies only at the next standard write.
// - upper six delay bits delay luma; applies at next standard write.
module vsi_regs (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [9:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// decoder configuration
	output vsi_pkg::vsi_cfg_t cfg,
	output logic             hpll_setup,
	output logic             acc_setup,
	output logic             init_busy,
	// interrupt
	output logic             irq
);

	// ==================================================================
	// address decode
	function automatic logic hit(input logic [9:0] a, input logic [7:0] i);
		hit = a[9:2] == i && a[1:0] == 2'h0;
	endfunction : hit

	wire hit_std  = hit(paddr, vsi_pkg::IDX_STD_SEL);
	wire hit_inp  = hit(paddr, vsi_pkg::IDX_INP_SEL);
	wire hit_pic  = hit(paddr, vsi_pkg::IDX_PIC_POS);
	wire hit_dly  = hit(paddr, vsi_pkg::IDX_DLY_ADJ);
	wire hit_stat = hit(paddr, vsi_pkg::IDX_IRQ_STAT);
	wire hit_mask = hit(paddr, vsi_pkg::IDX_IRQ_MASK);
	wire mapped   = hit_std | hit_inp | hit_pic | hit_dly | hit_stat |
		hit_mask;

	wire        xfer = psel & penable;
	wire        wr   = xfer & pwrite & mapped;
	wire [11:0] wd   = pwdata[11:0];

	wire wr_std  = wr & hit_std;
	wire wr_inp  = wr & hit_inp;
	wire wr_pic  = wr & hit_pic;
	wire wr_dly  = wr & hit_dly;
	wire wr_stat = wr & hit_stat;
	wire wr_mask = wr & hit_mask;

	assign pready  = 1'b1;
	assign pslverr = xfer & ~mapped;

	// ==================================================================
	// registers
	logic [11:0]       std_sel_ff, inp_sel_ff, pic_ff, dly_ff;
	logic [11:0]       nxt_std_sel_ff, nxt_inp_sel_ff;
	logic [1:0]        stat_ff, mask_ff, nxt_stat_ff;
	logic              pend_std_ff, pend_inp_ff;
	vsi_pkg::vsi_cfg_t cfg_ff, nxt_cfg_ff;

	logic seq_load, seq_done;

	wire done_std = seq_done & pend_std_ff;
	wire done_inp = seq_done & pend_inp_ff;

	// reserved bits are dropped so they always read back as zero
	wire [11:0] std_keep = wr_std ? (wd & vsi_pkg::STD_WMASK) : std_sel_ff;
	wire [11:0] inp_keep = wr_inp ? (wd & vsi_pkg::INP_WMASK) : inp_sel_ff;

	// completion beats a same-cycle software write of zero
	assign nxt_std_sel_ff = done_std ? (std_keep | vsi_pkg::DONE_MASK) :
		std_keep;
	assign nxt_inp_sel_ff = done_inp ? (inp_keep | vsi_pkg::DONE_MASK) :
		inp_keep;

	assign nxt_stat_ff = (stat_ff & ~(wr_stat ? wd[1:0] : 2'h0)) |
		{done_inp, done_std};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			std_sel_ff <= vsi_pkg::STD_RST;
			inp_sel_ff <= vsi_pkg::INP_RST;
			pic_ff     <= vsi_pkg::PIC_RST;
			dly_ff     <= vsi_pkg::DLY_RST;
			stat_ff    <= 2'h0;
			mask_ff    <= 2'h0;
		end else begin
			std_sel_ff <= nxt_std_sel_ff;
			inp_sel_ff <= nxt_inp_sel_ff;
			pic_ff     <= wr_pic ? wd : pic_ff;
			dly_ff     <= wr_dly ? (wd & vsi_pkg::DLY_WMASK) : dly_ff;
			stat_ff    <= nxt_stat_ff;
			mask_ff    <= wr_mask ? wd[1:0] : mask_ff;
		end
	end

	// a write during a running setup keeps its own completion pending
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_std_ff <= 1'b0;
			pend_inp_ff <= 1'b0;
		end else begin
			pend_std_ff <= wr_std | (pend_std_ff & ~seq_done);
			pend_inp_ff <= wr_inp | (pend_inp_ff & ~seq_done);
		end
	end

	// ==================================================================
	// initialization sequencer
	vsi_init_seq u_seq (
		.pclk       (pclk),
		.presetn    (presetn),
		.start      (wr_std | wr_inp),
		.skip_hpll  (nxt_std_sel_ff[vsi_pkg::NO_HPLL_BIT]),
		.skip_acc   (nxt_std_sel_ff[vsi_pkg::NO_ACC_BIT]),
		.load       (seq_load),
		.hpll_setup (hpll_setup),
		.acc_setup  (acc_setup),
		.done       (seq_done),
		.busy       (init_busy)
	);

	// ==================================================================
	// standard decode
	wire [2:0] std_code = std_sel_ff[vsi_pkg::STD_LSB +: vsi_pkg::STD_W];
	wire       std_mod  = std_sel_ff[vsi_pkg::MOD_BIT];
	wire is_secam = std_code == vsi_pkg::STD_SECAM;
	wire is_ntscc = std_code == vsi_pkg::STD_NTSCC;
	wire is_ntsc  = std_code == vsi_pkg::STD_NTSC_M ||
		std_code == vsi_pkg::STD_NTSC44;
	wire is_pal   = std_code == vsi_pkg::STD_PAL ||
		std_code == vsi_pkg::STD_PAL_M || std_code == vsi_pkg::STD_PAL_N ||
		std_code == vsi_pkg::STD_PAL60;
	wire is_50hz  = std_code == vsi_pkg::STD_PAL || is_secam ||
		std_code == vsi_pkg::STD_PAL_N;

	wire [1:0] luma_code = inp_sel_ff[vsi_pkg::LUMA_LSB +: 2];
	wire [1:0] ifc_code  = inp_sel_ff[vsi_pkg::IFC_LSB +: 2];
	wire [1:0] hspd_code = inp_sel_ff[vsi_pkg::HSPD_LSB +: 2];

	// one-hot {video_input_one, video_input_two, video_input_three};
	// the reserved code selects nothing
	wire [2:0] luma_oh = {luma_code == vsi_pkg::LUMA_IN1,
		luma_code == vsi_pkg::LUMA_IN2,
		luma_code == vsi_pkg::LUMA_IN3};

	// the 10 dB/MHz setting is only meaningful for SECAM
	wire [1:0] ifc_eff = (ifc_code == vsi_pkg::IFC_SECAM && !is_secam) ?
		vsi_pkg::IFC_OFF : ifc_code;

	always_comb begin
		nxt_cfg_ff             = cfg_ff;
		nxt_cfg_ff.std         = vsi_pkg::vsi_std_t'(std_code);
		nxt_cfg_ff.simple_pal  = std_mod & is_pal;
		nxt_cfg_ff.comp_ntsc   = std_mod & is_ntsc;
		nxt_cfg_ff.mono        = std_mod & (is_secam | is_ntscc);
		nxt_cfg_ff.lines625    = is_50hz;
		nxt_cfg_ff.svhs        = std_sel_ff[vsi_pkg::SVHS_BIT];
		nxt_cfg_ff.luma_sel    = luma_oh;
		nxt_cfg_ff.chroma_pin  = inp_sel_ff[vsi_pkg::CHROMA_BIT];
		nxt_cfg_ff.ifc         = ifc_eff;
		nxt_cfg_ff.cbw         = inp_sel_ff[vsi_pkg::CBW_LSB +: 2];
		nxt_cfg_ff.notch_fixed = inp_sel_ff[vsi_pkg::NOTCH_BIT];
		nxt_cfg_ff.lowpass     = inp_sel_ff[vsi_pkg::LOWP_BIT];
		if (hspd_code != vsi_pkg::HSPD_KEEP) begin
			nxt_cfg_ff.hpll_speed = hspd_code;
		end
		// position and delay wait for a standard write, not an input write
		if (pend_std_ff) begin
			nxt_cfg_ff.pic_start = pic_ff;
			// range kept by software, passed as two's complement
			nxt_cfg_ff.luma_dly  = dly_ff[vsi_pkg::DLY_LSB +: 6];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= '0;
		end else if (seq_load) begin
			cfg_ff <= nxt_cfg_ff;
		end
	end

	assign cfg = cfg_ff;
	assign irq = |(stat_ff & mask_ff);

	// ==================================================================
	// read back
	wire [11:0] rd = hit_std  ? std_sel_ff :
		hit_inp  ? inp_sel_ff :
		hit_pic  ? pic_ff :
		hit_dly  ? dly_ff :
		hit_stat ? {10'h000, stat_ff} :
		hit_mask ? {10'h000, mask_ff} : 12'h000;

	// captured at the setup edge so read data leaves a flip-flop; a status
	// bit set at that very edge only shows up on the next read
	logic [31:0] prdata_ff;
	wire         apb_setup = psel & ~penable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h00000000;
		end else begin
			prdata_ff <= apb_setup ? {20'h00000, rd} : prdata_ff;
		end
	end

	assign prdata = prdata_ff;

	// ==================================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	localparam int DONE_MAX = 30;

	sequence s_std_write;
		wr_std;
	endsequence

	sequence s_quiet_to_done;
		!(wr_std | wr_inp) throughout ##[4:DONE_MAX] seq_done;
	endsequence

	property p_std_done;
		s_std_write ##1 s_quiet_to_done |=> std_sel_ff[vsi_pkg::DONE_BIT];
	endproperty
	a_std_done: assert property (p_std_done)
		else $error("standard status not set after switching");

	property p_inp_done;
		wr_inp ##1 s_quiet_to_done |=> inp_sel_ff[vsi_pkg::DONE_BIT] &&
			stat_ff[vsi_pkg::IRQ_INP];
	endproperty
	a_inp_done: assert property (p_inp_done)
		else $error("input status not set after completion");

	property p_inp_starts;
		wr_inp |=> init_busy && seq_load;
	endproperty
	a_inp_starts: assert property (p_inp_starts)
		else $error("input write did not start initialization");

	property p_pic_hold;
		!(seq_load && pend_std_ff) |=> $stable(cfg_ff.pic_start);
	endproperty
	a_pic_hold: assert property (p_pic_hold)
		else $error("picture start changed without standard write");

	property p_dly_apply;
		seq_load && pend_std_ff |=>
			cfg_ff.luma_dly == $past(dly_ff[11:6]);
	endproperty
	a_dly_apply: assert property (p_dly_apply)
		else $error("luma delay not applied at standard write");

	property p_ifc_secam;
		cfg_ff.ifc == vsi_pkg::IFC_SECAM |-> cfg_ff.std == vsi_pkg::STD_SECAM;
	endproperty
	a_ifc_secam: assert property (p_ifc_secam)
		else $error("10 dB/MHz compensation outside SECAM");

	property p_luma_one;
		seq_load |=> $countones(cfg_ff.luma_sel) ==
			($past(luma_code) == 2'h3 ? 0 : 1);
	endproperty
	a_luma_one: assert property (p_luma_one)
		else $error("luma selection not one-hot");

	property p_std_load;
		seq_load |=> cfg_ff.std == $past(std_code) &&
			cfg_ff.mono == $past(std_mod && (is_secam || is_ntscc));
	endproperty
	a_std_load: assert property (p_std_load)
		else $error("active standard differs from register");

	property p_svhs;
		seq_load |=> cfg_ff.svhs == $past(std_sel_ff[vsi_pkg::SVHS_BIT]);
	endproperty
	a_svhs: assert property (p_svhs)
		else $error("separate luma/chroma mode not applied");

	property p_std_set_wins;
		seq_done && pend_std_ff |=> std_sel_ff[vsi_pkg::DONE_BIT] &&
			stat_ff[vsi_pkg::IRQ_STD];
	endproperty
	a_std_set_wins: assert property (p_std_set_wins)
		else $error("standard completion lost to a same-cycle clear");

	property p_inp_set_wins;
		seq_done && pend_inp_ff |=> inp_sel_ff[vsi_pkg::DONE_BIT] &&
			stat_ff[vsi_pkg::IRQ_INP];
	endproperty
	a_inp_set_wins: assert property (p_inp_set_wins)
		else $error("input completion lost to a same-cycle clear");

endmodule : vsi_regs

`default_nettype wire

// ### rtl/vsi_pkg.sv
/*
 * vsi_pkg: register map, field layout, reset values, state codes and the
 * configuration carrier of the video standard and input select registers.
 * Assumes a 200 MHz pclk and an APB master with 32-bit data.
 */
package vsi_pkg;

	// ==================================================================
	// register indexes, byte address is four times the index
	localparam logic [7:0]  IDX_STD_SEL  = 8'h20;
	localparam logic [7:0]  IDX_INP_SEL  = 8'h21;
	localparam logic [7:0]  IDX_PIC_POS  = 8'h22;
	localparam logic [7:0]  IDX_DLY_ADJ  = 8'h23;
	localparam logic [7:0]  IDX_IRQ_STAT = 8'h24;
	localparam logic [7:0]  IDX_IRQ_MASK = 8'h25;
	localparam int          REG_W        = 12;
	localparam int          IRQ_W        = 2;

	// ==================================================================
	// fields of the standard selection register
	localparam int          STD_LSB      = 0;
	localparam int          STD_W        = 3;
	localparam int          MOD_BIT      = 3;
	localparam int          SVHS_BIT     = 5;
	localparam int          NO_HPLL_BIT  = 6;
	localparam int          NO_ACC_BIT   = 7;
	localparam int          DONE_BIT     = 11;
	localparam logic [11:0] DONE_MASK    = 12'h800;
	localparam logic [11:0] STD_WMASK    = 12'h0ef;
	localparam logic [11:0] STD_RST      = 12'h000;

	// fields of the input selection register
	localparam int          LUMA_LSB     = 0;
	localparam int          CHROMA_BIT   = 2;
	localparam int          IFC_LSB      = 3;
	localparam int          CBW_LSB      = 5;
	localparam int          LOWP_BIT     = 7;
	localparam int          NOTCH_BIT    = 8;
	localparam int          HSPD_LSB     = 9;
	localparam logic [11:0] INP_WMASK    = 12'h7ff;
	localparam logic [11:0] INP_RST      = 12'h024;

	// picture start and luma delay
	localparam logic [11:0] PIC_RST      = 12'h000;
	localparam int          DLY_LSB      = 6;
	localparam logic [11:0] DLY_WMASK    = 12'hfc0;
	localparam logic [11:0] DLY_RST      = 12'h000;

	// interrupt status bits
	localparam int          IRQ_STD      = 0;
	localparam int          IRQ_INP      = 1;

	// ==================================================================
	// codes
	typedef enum logic [2:0] {
		STD_PAL    = 3'h0, STD_NTSC_M = 3'h1, STD_SECAM  = 3'h2,
		STD_NTSC44 = 3'h3, STD_PAL_M  = 3'h4, STD_PAL_N  = 3'h5,
		STD_PAL60  = 3'h6, STD_NTSCC  = 3'h7
	} vsi_std_t;

	localparam logic [1:0]  LUMA_IN3     = 2'h0;
	localparam logic [1:0]  LUMA_IN2     = 2'h1;
	localparam logic [1:0]  LUMA_IN1     = 2'h2;
	localparam logic [1:0]  IFC_OFF      = 2'h0;
	localparam logic [1:0]  IFC_SECAM    = 2'h3;
	localparam logic [1:0]  HSPD_KEEP    = 2'h0;

	typedef enum logic [5:0] {
		S_IDLE   = 6'h01, S_LOAD = 6'h02, S_HPLL = 6'h04,
		S_ACC    = 6'h08, S_SETTLE = 6'h10, S_DONE = 6'h20
	} vsi_seq_t;

	// ==================================================================
	// timing
	localparam int          CLK_NS       = 5;
	localparam int          SETTLE_NS    = 80;
	localparam int          SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

	// ==================================================================
	// active configuration handed to the decoder
	typedef struct packed {
		vsi_std_t          std;
		logic              simple_pal;
		logic              comp_ntsc;
		logic              mono;
		logic              lines625;
		logic              svhs;
		logic [2:0]        luma_sel;
		logic              chroma_pin;
		logic [1:0]        ifc;
		logic [1:0]        cbw;
		logic              notch_fixed;
		logic              lowpass;
		logic [1:0]        hpll_speed;
		logic [11:0]       pic_start;
		logic signed [5:0] luma_dly;
	} vsi_cfg_t;

endpackage : vsi_pkg

// ### rtl/vsi_init_seq.sv
/*
 * vsi_init_seq: models the firmware processor stepping through a standard
 * initialization: load, optional hpll and acc setup, settle, done.
 * Assumes start is a one-cycle pulse from the register block on pclk.
 */
`timescale 1ns/10ps
`default_nettype none

module vsi_init_seq (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// request
	input  wire logic start,
	input  wire logic skip_hpll,
	input  wire logic skip_acc,
	// progress
	output logic      load,
	output logic      hpll_setup,
	output logic      acc_setup,
	output logic      done,
	output logic      busy
);

	// ==================================================================
	// state
	vsi_pkg::vsi_seq_t st_ff, nxt_st_ff;
	logic [4:0]        cnt_ff, nxt_cnt_ff;
	logic              skh_ff, ska_ff;

	wire settle_end = cnt_ff == 5'(vsi_pkg::SETTLE_CYC - 1);

	always_comb begin
		nxt_st_ff = st_ff;
		case (st_ff)
			vsi_pkg::S_IDLE:   nxt_st_ff = vsi_pkg::S_IDLE;
			vsi_pkg::S_LOAD:   nxt_st_ff = !skh_ff ? vsi_pkg::S_HPLL :
				!ska_ff ? vsi_pkg::S_ACC : vsi_pkg::S_SETTLE;
			vsi_pkg::S_HPLL:   nxt_st_ff = !ska_ff ? vsi_pkg::S_ACC :
				vsi_pkg::S_SETTLE;
			vsi_pkg::S_ACC:    nxt_st_ff = vsi_pkg::S_SETTLE;
			vsi_pkg::S_SETTLE: nxt_st_ff = settle_end ? vsi_pkg::S_DONE :
				vsi_pkg::S_SETTLE;
			vsi_pkg::S_DONE:   nxt_st_ff = vsi_pkg::S_IDLE;
			default:           nxt_st_ff = vsi_pkg::S_IDLE;
		endcase
		// a new write restarts the whole setup with the newest settings
		if (start) begin
			nxt_st_ff = vsi_pkg::S_LOAD;
		end
	end

	assign nxt_cnt_ff = (st_ff == vsi_pkg::S_SETTLE && !start) ?
		cnt_ff + 5'h01 : 5'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff  <= vsi_pkg::S_IDLE;
			cnt_ff <= 5'h00;
			skh_ff <= 1'b0;
			ska_ff <= 1'b0;
		end else begin
			st_ff  <= nxt_st_ff;
			cnt_ff <= nxt_cnt_ff;
			if (start) begin
				skh_ff <= skip_hpll;
				ska_ff <= skip_acc;
			end
		end
	end

	assign load       = st_ff == vsi_pkg::S_LOAD;
	assign hpll_setup = st_ff == vsi_pkg::S_HPLL;
	assign acc_setup  = st_ff == vsi_pkg::S_ACC;
	assign done       = st_ff == vsi_pkg::S_DONE;
	assign busy       = st_ff != vsi_pkg::S_IDLE;

	// ==================================================================
	// checks
	sequence s_start_skip_hpll;
		start && skip_hpll;
	endsequence

	property p_no_hpll;
		@(posedge pclk) disable iff (!presetn)
		s_start_skip_hpll ##1 !start |=> !hpll_setup;
	endproperty
	a_no_hpll: assert property (p_no_hpll)
		else $error("hpll setup ran although suppressed");

	property p_no_acc;
		@(posedge pclk) disable iff (!presetn)
		(start && skip_acc) ##1 (!start)[*3] |-> !acc_setup && !$past(acc_setup);
	endproperty
	a_no_acc: assert property (p_no_acc)
		else $error("acc setup ran although suppressed");

endmodule : vsi_init_seq

`default_nettype wire

// ### bench/vsi_regs_tb.sv
/*
 * vsi_regs_tb: self-checking bench for the standard and input select
 * registers. An APB driver notes expected answers in queues and a monitor
 * compares them as reads complete and as each initialization ends.
 * Assumes vsi_pkg and vsi_regs are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module vsi_regs_tb;

	// =====================================================
	// signals and expectation queues
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [9:0]        paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	vsi_pkg::vsi_cfg_t cfg;
	logic              hpll_setup;
	logic              acc_setup;
	logic              init_busy;
	logic              irq;

	typedef struct packed {
		logic [31:0] d;
		logic        err;
		logic        irq;
	} vsi_rd_t;

	typedef struct packed {
		vsi_pkg::vsi_cfg_t c;
		vsi_pkg::vsi_cfg_t m;
		logic [1:0]        hp;
		logic [1:0]        ac;
	} vsi_init_t;

	vsi_rd_t           rd_q[$];
	vsi_init_t         in_q[$];
	int                fail_count  = 0;
	int                comparisons = 0;
	logic [11:0]       sh_std      = 12'h000;
	logic [11:0]       sh_inp      = 12'h024;
	logic [11:0]       sh_pic      = 12'h000;
	logic [11:0]       sh_dly      = 12'h000;
	logic [1:0]        sh_mask     = 2'h0;
	logic [1:0]        sh_stat     = 2'h0;
	vsi_pkg::vsi_cfg_t ecfg        = '0;
	logic [1:0]        n_hp        = 2'h0;
	logic [1:0]        n_ac        = 2'h0;
	logic              busy_q      = 1'b0;
	vsi_rd_t           r;
	vsi_init_t         e;

	vsi_regs i_dut (
		.pclk       (pclk),
		.presetn    (presetn),
		.psel       (psel),
		.penable    (penable),
		.pwrite     (pwrite),
		.paddr      (paddr),
		.pwdata     (pwdata),
		.prdata     (prdata),
		.pready     (pready),
		.pslverr    (pslverr),
		.cfg        (cfg),
		.hpll_setup (hpll_setup),
		.acc_setup  (acc_setup),
		.init_busy  (init_busy),
		.irq        (irq)
	);

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// =====================================================
	// compare, verdict, helpers
	task automatic check(input string nm, input logic [63:0] s,
		input logic [63:0] x);
		comparisons++;
		if (s !== x) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask : check

	task automatic wrap_up;
		if (fail_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	function automatic logic [9:0] ad(input logic [7:0] x);
		return {x, 2'b00};
	endfunction : ad

	// =====================================================
	// monitor: reads at the access edge, config at end of init
	always @(posedge pclk) begin
		if (psel && penable && pready) begin
			r = rd_q.pop_front();
			check("pslverr", 64'(pslverr), 64'(r.err));
			if (!pwrite) begin
				check("prdata", 64'(prdata), 64'(r.d));
				check("irq", 64'(irq), 64'(r.irq));
			end
		end
		if (init_busy === 1'b1 && busy_q !== 1'b1) begin
			n_hp = 2'h0;
			n_ac = 2'h0;
		end
		if (hpll_setup === 1'b1)
			n_hp++;
		if (acc_setup === 1'b1)
			n_ac++;
		if (init_busy === 1'b0 && busy_q === 1'b1) begin
			e = in_q.pop_front();
			check("cfg", 64'(cfg & e.m), 64'(e.c & e.m));
			check("hpll_setup", 64'(n_hp), 64'(e.hp));
			check("acc_setup", 64'(n_ac), 64'(e.ac));
		end
		busy_q = init_busy;
	end

	// =====================================================
	// apb master: holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [9:0] a,
		input logic [11:0] wd, input logic [31:0] ed, input logic ee);
		int n;
		rd_q.push_back('{ed, ee, |(sh_stat & sh_mask)});
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= 32'(wd);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			fail_count++;
			wrap_up();
		end
	endtask : apb

	task automatic push_cfg(input logic inp);
		vsi_pkg::vsi_cfg_t m;
		logic [2:0]        c;
		logic              md;
		c  = sh_std[2:0];
		md = sh_std[3];
		m  = '1;
		ecfg.std        = vsi_pkg::vsi_std_t'(c);
		ecfg.simple_pal = md && c == 3'h0;
		ecfg.comp_ntsc  = md && c == 3'h1;
		ecfg.mono       = md && (c == 3'h2 || c == 3'h7);
		ecfg.lines625   = c == 3'h2;
		ecfg.svhs       = sh_std[5];
		ecfg.luma_sel   = 3'b001 << sh_inp[1:0];
		ecfg.chroma_pin = sh_inp[2];
		ecfg.ifc        = (sh_inp[4:3] == 2'h3 && c != 3'h2) ? 2'h0
			: sh_inp[4:3];
		ecfg.cbw         = sh_inp[6:5];
		ecfg.lowpass     = sh_inp[7];
		ecfg.notch_fixed = sh_inp[8];
		if (sh_inp[10:9] != 2'h0)
			ecfg.hpll_speed = sh_inp[10:9];
		// position and delay wait for a standard write
		if (!inp) begin
			ecfg.pic_start = sh_pic;
			ecfg.luma_dly  = sh_dly[11:6];
		end
		// modifier meaning is only pinned down for these codes
		m.simple_pal = c == 3'h0;
		m.comp_ntsc  = c == 3'h1;
		m.mono       = c == 3'h2 || c == 3'h7;
		m.lines625   = md && m.mono;
		in_q.push_back('{ecfg, m, {1'b0, !sh_std[6]}, {1'b0, !sh_std[7]}});
	endtask : push_cfg

	// clear status, write, see status low, wait, see status set and irq as the mask allows
	task automatic do_init(input logic inp, input logic [11:0] wd);
		logic [9:0] a;
		logic [1:0] st;
		int         n;
		a  = ad(inp ? vsi_pkg::IDX_INP_SEL : vsi_pkg::IDX_STD_SEL);
		wd = wd & (inp ? vsi_pkg::INP_WMASK : vsi_pkg::STD_WMASK);
		st = inp ? 2'b10 : 2'b01;
		sh_stat = 2'b00;
		apb(1'b1, ad(vsi_pkg::IDX_IRQ_STAT), 12'h003, '0, 1'b0);
		if (inp)
			sh_inp = wd;
		else
			sh_std = wd;
		apb(1'b1, a, wd, '0, 1'b0);
		push_cfg(inp);
		apb(1'b0, a, 12'h000, 32'(wd), 1'b0);
		n = 0;
		while (init_busy !== 1'b0 && n < 60) begin
			@(posedge pclk);
			n++;
		end
		repeat (4) @(posedge pclk);
		sh_stat = st;
		apb(1'b0, a, 12'h000, 32'(wd | vsi_pkg::DONE_MASK), 1'b0);
		apb(1'b0, ad(vsi_pkg::IDX_IRQ_STAT), 12'h000, 32'(st), 1'b0);
		if (n >= 60) begin
			fail_count++;
			wrap_up();
		end
	endtask : do_init

	// =====================================================
	// main sequence
	initial begin
		logic [11:0] rst_v[6];
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = '0;
		pwdata  = '0;
		presetn = 1'b0;
		rst_v   = '{vsi_pkg::STD_RST, vsi_pkg::INP_RST, vsi_pkg::PIC_RST,
			vsi_pkg::DLY_RST, 12'h000, 12'h000};
		void'($urandom(18334));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			apb(1'b0, ad(8'(8'h20 + i)), 12'h000, 32'(rst_v[i]), 1'b0);
		// unmapped and misaligned places are refused
		apb(1'b0, 10'h098, 12'h000, 32'h0, 1'b1);
		apb(1'b1, 10'h09c, 12'hfff, 32'h0, 1'b1);
		apb(1'b1, 10'h082, 12'h007, 32'h0, 1'b1);
		apb(1'b0, 10'h081, 12'h000, 32'h0, 1'b1);
		apb(1'b0, ad(vsi_pkg::IDX_STD_SEL), 12'h000, 32'h0, 1'b0);
		sh_mask = 2'b11;
		apb(1'b1, ad(vsi_pkg::IDX_IRQ_MASK), 12'h003, '0, 1'b0);
		// every standard code with and without modifier, all option pairs
		for (int i = 0; i < 16; i++) begin
			if (i == 12) begin
				sh_mask = 2'b10;
				apb(1'b1, ad(vsi_pkg::IDX_IRQ_MASK), 12'h002, '0, 1'b0);
				apb(1'b0, ad(vsi_pkg::IDX_IRQ_MASK), 12'h000, 32'h2, 1'b0);
			end
			do_init(1'b0, {4'h0, 2'(i), 1'($urandom), 1'b0, 4'(i)});
		end
		// input selections; position and delay held until a standard write
		for (int i = 0; i < 8; i++) begin
			if (i == 2) begin
				sh_pic = 12'($urandom);
				sh_dly = 12'he40;
				apb(1'b1, ad(vsi_pkg::IDX_PIC_POS), sh_pic, '0, 1'b0);
				apb(1'b1, ad(vsi_pkg::IDX_DLY_ADJ), sh_dly, '0, 1'b0);
			end
			if (i == 4)
				do_init(1'b0, 12'h002);
			do_init(1'b1, (12'($urandom) & 12'h7fc) | 12'(i % 4));
		end
		sh_dly = 12'h040;
		apb(1'b1, ad(vsi_pkg::IDX_DLY_ADJ), sh_dly, '0, 1'b0);
		do_init(1'b0, 12'h0c7);
		sh_stat = 2'b00;
		apb(1'b1, ad(vsi_pkg::IDX_IRQ_STAT), 12'h003, '0, 1'b0);
		apb(1'b0, ad(vsi_pkg::IDX_IRQ_STAT), 12'h000, 32'h0, 1'b0);
		repeat (2) @(posedge pclk);
		check("init_left", 64'(in_q.size()), 64'h0);
		wrap_up();
	end

endmodule : vsi_regs_tb

`default_nettype wire
